// file: common/dsu_regs.vh
// Constants for the doubleword store unit.
`ifndef DSU_REGS_VH
`define DSU_REGS_VH
`define DSU_OP_STORE_DWORD     6'h3F
`define DSU_OP_STORE_FP_DWORD  6'h3D
`define DSU_OP_STORE_COND      6'h3C
`define DSU_OP_LOAD_LINKED     6'h34
`define DSU_OP_MSB             31
`define DSU_OP_LSB             26
`define DSU_BASE_MSB           25
`define DSU_BASE_LSB           21
`define DSU_SRC_MSB            20
`define DSU_SRC_LSB            16
`define DSU_OFS_MSB            15
`define DSU_ALIGN_BITS         3
`define DSU_BLOCK_SHIFT        3
`define DSU_ALL_LANES          8'hFF
`define DSU_EXC_NONE           3'h0
`define DSU_EXC_ADDR_ERR       3'h1
`define DSU_EXC_TLB_REFILL     3'h2
`define DSU_EXC_TLB_INVALID    3'h3
`define DSU_EXC_TLB_MODIFIED   3'h4
`define DSU_EXC_RESERVED_INSTR 3'h5
`define DSU_EXC_COP_UNUSABLE   3'h6
`define DSU_FAIL_ON_EXC        2'h1
`define DSU_FAIL_ON_RETURN     2'h2
`endif

// file: rtl/dsu_link_watch.v
// Link flag tracker for the linked load and conditional store pair.
`include "dsu_regs.vh"
`default_nettype none
module dsu_link_watch
(
  // Clock and reset.
  input  wire        clock,
  input  wire        sys_rst,
  // Link events.
  input  wire        set_link,
  input  wire [63:0] set_paddr,
  input  wire        clear_link,
  input  wire [1:0]  fail_mode,
  input  wire        exc_taken,
  input  wire        exc_return,
  input  wire        snoop_store,
  input  wire [63:0] snoop_paddr,
  // Link state.
  output reg         link_flag_r,
  output reg  [63:0] link_paddr_r
);
  wire snoop_hit;
  wire exc_kill;
  assign snoop_hit = snoop_store &&
    (snoop_paddr[63:`DSU_BLOCK_SHIFT] == link_paddr_r[63:`DSU_BLOCK_SHIFT]);
  assign exc_kill = (exc_taken && fail_mode[0]) || (exc_return && fail_mode[1]);
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      link_flag_r  <= 1'b0;
      link_paddr_r <= 64'h0;
    end
    else if (set_link)
    begin
      link_flag_r  <= 1'b1;
      link_paddr_r <= set_paddr;
    end
    else if (snoop_hit || exc_kill || clear_link)
    begin
      link_flag_r <= 1'b0;
    end
  end
endmodule // dsu_link_watch
`default_nettype wire

// file: rtl/dsu_store_unit.v
// Doubleword store unit: plain, floating-point and conditional stores.
`include "dsu_regs.vh"
`default_nettype none
module dsu_store_unit
(
  // Clock and reset.
  input  wire        clock,
  input  wire        sys_rst,
  // Instruction issue.
  input  wire        issue_valid,
  input  wire [31:0] issue_instr,
  input  wire        issue_reserved,
  input  wire        fpu_usable,
  // Register file operands.
  input  wire [63:0] base_value,
  input  wire [63:0] src_gpr_value,
  input  wire [63:0] src_fpr_value,
  // Linked load completion and link events.
  input  wire        ll_done,
  input  wire [63:0] ll_paddr,
  input  wire [1:0]  fail_mode,
  input  wire        exc_taken,
  input  wire        exc_return,
  input  wire        snoop_store,
  input  wire [63:0] snoop_paddr,
  // Address translation.
  input  wire        xlat_ready,
  input  wire [63:0] xlat_paddr,
  input  wire [2:0]  xlat_cca,
  input  wire [2:0]  xlat_exc,
  // Memory write.
  input  wire        mem_ready,
  // Outputs: register selects.
  output reg  [4:0]  base_sel_r,
  output reg  [4:0]  src_sel_r,
  // Outputs: translation request.
  output reg         xlat_req_r,
  output reg  [63:0] xlat_vaddr_r,
  // Outputs: memory write.
  output reg         mem_wr_r,
  output reg  [63:0] mem_addr_r,
  output reg  [2:0]  mem_cca_r,
  output reg  [63:0] mem_wdata_r,
  output reg  [7:0]  mem_lanes_r,
  // Outputs: results.
  output reg         busy_r,
  output reg         done_r,
  output reg  [2:0]  exc_code_r,
  output reg         gpr_wr_r,
  output reg  [4:0]  gpr_wr_sel_r,
  output reg  [63:0] gpr_wr_data_r,
  output reg         link_flag_out_r
);
  localparam ST_IDLE  = 4'b0001;
  localparam ST_ADDR  = 4'b0010;
  localparam ST_XLAT  = 4'b0100;
  localparam ST_WRITE = 4'b1000;

  reg  [3:0]  state_r;
  reg  [3:0]  state_nxt;
  reg  [1:0]  kind_r;
  reg  [15:0] offset_r;
  reg  [63:0] data_r;
  wire [5:0]  opcode;
  wire [1:0]  kind_dec;
  wire        dec_valid;
  wire [63:0] eff_addr;
  wire        misaligned;
  wire        link_flag;
  wire [63:0] link_paddr;
  wire        clear_link;

  localparam K_PLAIN = 2'h0;
  localparam K_FP    = 2'h1;
  localparam K_COND  = 2'h2;

  assign opcode   = issue_instr[`DSU_OP_MSB:`DSU_OP_LSB];
  assign kind_dec = (opcode == `DSU_OP_STORE_FP_DWORD) ? K_FP :
                    (opcode == `DSU_OP_STORE_COND)     ? K_COND : K_PLAIN;
  assign dec_valid = (opcode == `DSU_OP_STORE_DWORD) || (opcode == `DSU_OP_STORE_FP_DWORD) ||
                     (opcode == `DSU_OP_STORE_COND);
  assign eff_addr = base_value + {{48{offset_r[`DSU_OFS_MSB]}}, offset_r};
  assign misaligned = |eff_addr[`DSU_ALIGN_BITS-1:0];
  assign clear_link = (state_r == ST_WRITE) && (kind_r == K_COND) && mem_ready;

  dsu_link_watch u_link
  (
    .clock        (clock),
    .sys_rst      (sys_rst),
    .set_link     (ll_done),
    .set_paddr    (ll_paddr),
    .clear_link   (clear_link),
    .fail_mode    (fail_mode),
    .exc_taken    (exc_taken),
    .exc_return   (exc_return),
    .snoop_store  (snoop_store),
    .snoop_paddr  (snoop_paddr),
    .link_flag_r  (link_flag),
    .link_paddr_r (link_paddr)
  );

  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:  if (issue_valid && !issue_reserved && dec_valid &&
                    !(kind_dec == K_FP && !fpu_usable)) state_nxt = ST_ADDR;
      ST_ADDR:  state_nxt = misaligned ? ST_IDLE : ST_XLAT;
      ST_XLAT:
        if (xlat_ready)
        begin
          if (xlat_exc != `DSU_EXC_NONE)
            state_nxt = ST_IDLE;
          else if (kind_r == K_COND && !link_flag)
            state_nxt = ST_IDLE;
          else
            state_nxt = ST_WRITE;
        end
      ST_WRITE: if (mem_ready) state_nxt = ST_IDLE;
      default:  state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      state_r         <= ST_IDLE;
      kind_r          <= K_PLAIN;
      offset_r        <= 16'h0000;
      data_r          <= 64'h0;
      base_sel_r      <= 5'h00;
      src_sel_r       <= 5'h00;
      xlat_req_r      <= 1'b0;
      xlat_vaddr_r    <= 64'h0;
      mem_wr_r        <= 1'b0;
      mem_addr_r      <= 64'h0;
      mem_cca_r       <= 3'h0;
      mem_wdata_r     <= 64'h0;
      mem_lanes_r     <= 8'h00;
      busy_r          <= 1'b0;
      done_r          <= 1'b0;
      exc_code_r      <= `DSU_EXC_NONE;
      gpr_wr_r        <= 1'b0;
      gpr_wr_sel_r    <= 5'h00;
      gpr_wr_data_r   <= 64'h0;
      link_flag_out_r <= 1'b0;
    end
    else
    begin
      state_r         <= state_nxt;
      done_r          <= 1'b0;
      gpr_wr_r        <= 1'b0;
      link_flag_out_r <= link_flag;
      case (state_r)
        ST_IDLE:
          if (issue_valid)
          begin
            kind_r     <= kind_dec;
            offset_r   <= issue_instr[`DSU_OFS_MSB:0];
            base_sel_r <= issue_instr[`DSU_BASE_MSB:`DSU_BASE_LSB];
            src_sel_r  <= issue_instr[`DSU_SRC_MSB:`DSU_SRC_LSB];
            exc_code_r <= `DSU_EXC_NONE;
            if (issue_reserved || !dec_valid)
            begin
              done_r     <= 1'b1;
              exc_code_r <= `DSU_EXC_RESERVED_INSTR;
            end
            else if (kind_dec == K_FP && !fpu_usable)
            begin
              done_r     <= 1'b1;
              exc_code_r <= `DSU_EXC_COP_UNUSABLE;
            end
            else
              busy_r <= 1'b1;
          end
        ST_ADDR:
        begin
          data_r <= (kind_r == K_FP) ? src_fpr_value : src_gpr_value;
          if (misaligned)
          begin
            busy_r     <= 1'b0;
            done_r     <= 1'b1;
            exc_code_r <= `DSU_EXC_ADDR_ERR;
          end
          else
          begin
            xlat_req_r   <= 1'b1;
            xlat_vaddr_r <= eff_addr;
          end
        end
        ST_XLAT:
          if (xlat_ready)
          begin
            xlat_req_r <= 1'b0;
            if (xlat_exc != `DSU_EXC_NONE)
            begin
              busy_r     <= 1'b0;
              done_r     <= 1'b1;
              exc_code_r <= xlat_exc;
            end
            else if (kind_r == K_COND && !link_flag)
            begin
              busy_r        <= 1'b0;
              done_r        <= 1'b1;
              gpr_wr_r      <= 1'b1;
              gpr_wr_sel_r  <= src_sel_r;
              gpr_wr_data_r <= 64'h0;
            end
            else
            begin
              mem_wr_r    <= 1'b1;
              mem_addr_r  <= xlat_paddr;
              mem_cca_r   <= xlat_cca;
              mem_wdata_r <= data_r;
              mem_lanes_r <= `DSU_ALL_LANES;
            end
          end
        ST_WRITE:
          if (mem_ready)
          begin
            mem_wr_r    <= 1'b0;
            mem_lanes_r <= 8'h00;
            busy_r      <= 1'b0;
            done_r      <= 1'b1;
            if (kind_r == K_COND)
            begin
              gpr_wr_r      <= 1'b1;
              gpr_wr_sel_r  <= src_sel_r;
              gpr_wr_data_r <= {63'h0, link_flag};
            end
          end
        default:
          busy_r <= 1'b0;
      endcase
    end
  end
endmodule // dsu_store_unit
`default_nettype wire

// file: tb/dsu_store_unit_properties.sv
// Assertion checker for the doubleword store unit.
`default_nettype none
module dsu_props
(
  // Clock and reset.
  input wire logic        clock,
  input wire logic        sys_rst,
  // Issue and results.
  input wire logic        issue_valid,
  input wire logic        issue_reserved,
  input wire logic        busy_r,
  input wire logic        done_r,
  input wire logic [2:0]  exc_code_r,
  input wire logic        gpr_wr_r,
  input wire logic [63:0] gpr_wr_data_r,
  // Translation and memory.
  input wire logic        xlat_req_r,
  input wire logic        xlat_ready,
  input wire logic [63:0] xlat_vaddr_r,
  input wire logic [63:0] xlat_paddr,
  input wire logic [2:0]  xlat_exc,
  input wire logic        mem_wr_r,
  input wire logic        mem_ready,
  input wire logic [63:0] mem_addr_r,
  input wire logic [7:0]  mem_lanes_r
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  lanes_full_a: assert property (mem_wr_r |-> mem_lanes_r == 8'hFF)
    else $error("write without all lanes");
  write_hold_a: assert property (mem_wr_r && !mem_ready |=> mem_wr_r && $stable(mem_addr_r))
    else $error("write dropped early");
  phys_addr_a: assert property ($rose(mem_wr_r) |-> mem_addr_r == $past(xlat_paddr))
    else $error("write address not translated");
  aligned_only_a: assert property (xlat_req_r |-> xlat_vaddr_r[2:0] == 3'h0)
    else $error("misaligned address translated");
  tlb_nowrite_a: assert property (xlat_req_r && xlat_ready && xlat_exc != 3'h0 |=> !mem_wr_r [*2])
    else $error("write after translation fault");
  reserved_exc_a: assert property (issue_valid && !busy_r && issue_reserved |=> done_r && exc_code_r == 3'h5)
    else $error("reserved instruction not reported");
  write_done_a: assert property (mem_wr_r && mem_ready |=> done_r && !mem_wr_r && !busy_r)
    else $error("no completion after write");
  flag_only_a: assert property (gpr_wr_r |-> done_r && gpr_wr_data_r[63:1] == 63'h0)
    else $error("result not a single flag bit");
  success_write_a: assert property (gpr_wr_r && gpr_wr_data_r[0] |-> $past(mem_wr_r && mem_ready))
    else $error("success without write");
  fail_nowrite_a: assert property (gpr_wr_r && !gpr_wr_data_r[0] |-> !$past(mem_wr_r))
    else $error("failure after write");
  cover property (gpr_wr_r && gpr_wr_data_r[0]);
  cover property (gpr_wr_r && !gpr_wr_data_r[0]);
  cover property (done_r && exc_code_r == 3'h1);
endmodule // dsu_props
bind dsu_store_unit dsu_props u_props (.*);
`default_nettype wire

// file: tb/dsu_mem_model.sv
// Translation and memory responder on the far side of the store unit.
`default_nettype none
module dsu_mem_model
#(parameter logic [63:0] FLIP = 64'h0)
(
  // Clock and stall setting.
  input  wire logic        clock,
  input  wire logic [1:0]  dly,
  // Requests.
  input  wire logic        xlat_req_r,
  input  wire logic [63:0] xlat_vaddr_r,
  input  wire logic        mem_wr_r,
  input  wire logic [63:0] mem_addr_r,
  input  wire logic [63:0] mem_wdata_r,
  // Answers.
  output logic             xlat_ready,
  output logic [63:0]      xlat_paddr,
  output logic [2:0]       xlat_cca,
  output logic             mem_ready,
  // Last write seen and count of writes.
  output logic [63:0]      wr_addr,
  output logic [63:0]      wr_data,
  output logic [7:0]       wr_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt = 2'h0;
  assign xlat_cca = 3'h5;
  assign xlat_ready = xlat_req_r && cnt == dly;
  assign xlat_paddr = xlat_ready ? xlat_vaddr_r ^ FLIP : ~xlat_vaddr_r;
  assign mem_ready = mem_wr_r && cnt == dly;
  initial wr_cnt = 8'h00;
  always @(posedge clock)
  begin
    cnt <= (xlat_ready || mem_ready || !(xlat_req_r || mem_wr_r)) ? 2'h0 : cnt + 2'h1;
    if (mem_ready)
    begin
      wr_addr <= mem_addr_r;
      wr_data <= mem_wdata_r;
      wr_cnt <= wr_cnt + 8'h01;
    end
  end
endmodule // dsu_mem_model
`default_nettype wire

// file: tb/dsu_store_unit_tb.sv
// Self-checking bench for the doubleword store unit.
`default_nettype none
`include "dsu_regs.vh"
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin failures++; $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module dsu_store_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [63:0] FLIP = 64'h0000_0100_0000_0000;
  logic clock = 0, sys_rst = 1, issue_valid = 0, issue_reserved = 0, fpu_usable = 1, ll_done = 0;
  logic exc_taken = 0, exc_return = 0, snoop_store = 0, xlat_ready, mem_ready;
  logic [31:0] issue_instr = 32'h0;
  logic [63:0] base_value = 64'h1000, src_gpr_value = 64'hA5A5_0123_4567_89AB, src_fpr_value = 64'h0FED_CBA9_8765_4321;
  logic [63:0] ll_paddr = 64'h0, snoop_paddr = 64'h0, xlat_paddr, xlat_vaddr_r, mem_addr_r, mem_wdata_r;
  logic [63:0] gpr_wr_data_r, wr_addr, wr_data;
  logic [1:0] fail_mode = 2'h1, dly = 2'h0;
  logic [2:0] xlat_cca, xlat_exc = 3'h0, mem_cca_r, exc_code_r;
  logic [4:0] base_sel_r, src_sel_r, gpr_wr_sel_r;
  logic [7:0] mem_lanes_r, wr_cnt;
  logic xlat_req_r, mem_wr_r, busy_r, done_r, gpr_wr_r, link_flag_out_r;
  int failures = 0, cmp_count = 0;
  dsu_store_unit DUT (.*);
  dsu_mem_model #(.FLIP(FLIP)) MEM (.*);
  initial forever #4 clock = ~clock;
  task print_verdict;
    if (failures == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(posedge clock);
    #1 s = 1'b0;
  endtask
  task automatic run(input logic [5:0] op, input logic [15:0] ofs, input logic [2:0] xe,
                     input logic [2:0] ex, input logic w, input logic [1:0] gr, input logic [63:0] d);
    logic [63:0] ea;
    logic [7:0]  n0;
    int          i;
    ea = base_value + {{48{ofs[15]}}, ofs};
    n0 = wr_cnt;
    issue_instr = {op, 5'h03, 5'h07, ofs};
    xlat_exc = xe;
    issue_valid = 1'b1;
    @(posedge clock);
    #1 issue_valid = 1'b0;
    i = 0;
    while (done_r !== 1'b1 && i < 60)
    begin
      @(posedge clock);
      #1 i++;
    end
    xlat_exc = 3'h0;
    `CHK("done", 1'b1, done_r)
    `CHK("exc", ex, exc_code_r)
    `CHK("busy", 1'b0, busy_r)
    `CHK("base_sel", 5'h03, base_sel_r)
    `CHK("src_sel", 5'h07, src_sel_r)
    `CHK("writes", n0 + {7'h0, w}, wr_cnt)
    if (w)
    begin
      `CHK("addr", ea ^ FLIP, wr_addr)
      `CHK("data", d, wr_data)
      `CHK("cca", 3'h5, mem_cca_r)
    end
    if (gr != 2'h2)
      `CHK("result", {1'b1, 5'h07, 63'h0, gr[0]}, {gpr_wr_r, gpr_wr_sel_r, gpr_wr_data_r})
  endtask
  task automatic link();
    ll_paddr = 64'h1000 ^ FLIP;
    pulse(ll_done);
    @(posedge clock);
    #1 `CHK("link_flag", 1'b1, link_flag_out_r)
  endtask
  initial
  begin
    repeat (10) @(posedge clock);
    #1 sys_rst = 1'b0;
    run(`DSU_OP_STORE_DWORD, 16'hFFF8, 0, 0, 1, 2, src_gpr_value);
    dly = 2'h3;
    run(`DSU_OP_STORE_DWORD, 16'h0010, 0, 0, 1, 2, src_gpr_value);
    run(`DSU_OP_STORE_FP_DWORD, 16'h0008, 0, 0, 1, 2, src_fpr_value);
    dly = 2'h0;
    fpu_usable = 1'b0;
    run(`DSU_OP_STORE_FP_DWORD, 16'h0000, 0, 6, 0, 2, 0);
    fpu_usable = 1'b1;
    run(`DSU_OP_STORE_DWORD, 16'h0004, 0, 1, 0, 2, 0);
    run(`DSU_OP_STORE_FP_DWORD, 16'h0001, 0, 1, 0, 2, 0);
    run(`DSU_OP_STORE_COND, 16'h0002, 0, 1, 0, 2, 0);
    for (int e = 2; e < 5; e++)
      run(`DSU_OP_STORE_DWORD, 16'h0000, e[2:0], e[2:0], 0, 2, 0);
    run(6'h00, 16'h0000, 0, 5, 0, 2, 0);
    issue_reserved = 1'b1;
    run(`DSU_OP_STORE_DWORD, 16'h0000, 0, 5, 0, 2, 0);
    issue_reserved = 1'b0;
    link();
    run(`DSU_OP_STORE_COND, 16'h0000, 0, 0, 1, 1, src_gpr_value);
    run(`DSU_OP_STORE_COND, 16'h0000, 0, 0, 0, 0, 0);
    link();
    snoop_paddr = 64'h1008 ^ FLIP;
    pulse(snoop_store);
    run(`DSU_OP_STORE_COND, 16'h0000, 0, 0, 1, 1, src_gpr_value);
    link();
    snoop_paddr = 64'h1007 ^ FLIP;
    pulse(snoop_store);
    run(`DSU_OP_STORE_COND, 16'h0000, 0, 0, 0, 0, 0);
    for (int m = 1; m < 4; m++)
    begin
      fail_mode = m[1:0];
      link();
      if (m[0])
        pulse(exc_taken);
      else
        pulse(exc_return);
      run(`DSU_OP_STORE_COND, 16'h0000, 0, 0, 0, 0, 0);
    end
    print_verdict;
  end
  initial
  begin
    repeat (3000) @(posedge clock);
    failures++;
    print_verdict;
  end
endmodule // dsu_store_unit_tb
`default_nettype wire
